// ===== inc/pxb_cfg.svh
// Crossbar constants: pin counts, fixed pin positions, select field layouts and reset values.
`ifndef PXB_CFG_SVH
`define PXB_CFG_SVH
`define PXB_NPINS 15
`define PXB_NFUNC 21
`define PXB_UART_TX_PIN 4
`define PXB_UART_RX_PIN 5
`define PXB_SPI2_BASE_PIN 8
`define PXB_SELA_UART 0
`define PXB_SELA_SECOND_SERIAL_PERIPH 1
`define PXB_SELA_SMB 2
`define PXB_SELA_SYSCK 3
`define PXB_SELA_CP0 4
`define PXB_SELA_COMPARATOR0_ASYNC_OUT 5
`define PXB_SELA_CP1 6
`define PXB_SELA_COMPARATOR1_ASYNC_OUT 7
`define PXB_SELB_CAP_LSB 0
`define PXB_SELB_ECI 3
`define PXB_SELB_T0 4
`define PXB_SELB_T1 5
`define PXB_SELB_SPI2 6
`define PXB_SELC_GLOBAL 6
`define PXB_CAP_RESERVED 3'h7
`define PXB_SEL_RESET 8'h00
`define PXB_MASK_RESET 8'h00
`define PXB_NSSMD_4WIRE_BIT 1
`endif

// ===== inc/pxb_pkg.sv
// Types shared by the crossbar decoder files.
package pxb_pkg;
	typedef logic [4:0] pxb_func_t;
	typedef logic [3:0] pxb_pin_t;
	typedef enum logic [1:0] {
		PXB_OWN_GPIO = 2'b00,
		PXB_OWN_FIXED = 2'b01,
		PXB_OWN_SEARCH = 2'b10
	} pxb_own_e;
endpackage

// ===== logic/pxb_pin_search.sv
// One priority stage: picks the lowest free pin for one function.
`timescale 1ns/1ps
`include "pxb_cfg.svh"
module pxb_pin_search (
	input wire logic want, // Function is selected and needs a pin
	input wire logic [`PXB_NPINS-1:0] freeIn, // Pins still free
	output logic [`PXB_NPINS-1:0] freeOut, // Free pins after this claim
	output logic [`PXB_NPINS-1:0] grant, // One-hot pin given, zero if none
	output logic found // A pin was granted
);
	wire logic [`PXB_NPINS-1:0] lowest;
	assign lowest = freeIn & (~freeIn + `PXB_NPINS'(1));
	assign grant = want ? lowest : '0;
	assign found = |grant;
	assign freeOut = freeIn & ~grant;
endmodule

// ===== logic/pxb_crossbar.sv
// Priority crossbar decoder: routes peripheral signals onto port pins 0.0 to 1.6.
`timescale 1ns/1ps
`include "pxb_cfg.svh"
module pxb_crossbar (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic clkEn, // Clock enable, freezes state when low
	input wire logic selWrA, // Write strobe for route_select_a
	input wire logic selWrB, // Write strobe for route_select_b
	input wire logic selWrC, // Write strobe for route_select_c
	input wire logic maskWr0, // Write strobe for port0_reserve_mask
	input wire logic maskWr1, // Write strobe for port1_reserve_mask
	input wire logic [7:0] wrData, // Write data for select and mask registers
	output logic [7:0] routeSelectA, // Current route_select_a
	output logic [7:0] routeSelectB, // Current route_select_b
	output logic [7:0] routeSelectC, // Current route_select_c
	output logic [7:0] port0ReserveMask, // Current port0_reserve_mask
	output logic [7:0] port1ReserveMask, // Current port1_reserve_mask
	input wire logic [1:0] slaveSelectMode, // First serial port slave-select mode
	input wire logic [`PXB_NPINS-1:0] pinDriveType, // Per-pin push-pull when one
	input wire logic [`PXB_NPINS-1:0] pinDigital, // Per-pin digital mode when one
	input wire logic [`PXB_NPINS-1:0] portLatch, // Port output latch values
	input wire logic [`PXB_NPINS-1:0] padIn, // Pad input levels
	input wire logic [`PXB_NFUNC-1:0] periphOut, // Peripheral output values, priority order
	input wire logic [`PXB_NFUNC-1:0] periphOe, // Peripheral wants to drive, priority order
	input wire logic uartTx, // Async serial port transmit
	input wire logic [3:0] spi2Out, // Second serial port outputs, pins 1.0 to 1.3
	input wire logic [3:0] spi2Oe, // Second serial port output drives
	output logic uartRx, // Async serial port receive
	output logic [3:0] spi2In, // Second serial port inputs
	output logic [`PXB_NFUNC-1:0] periphIn, // Pad level seen by each routed function
	output logic [`PXB_NFUNC-1:0] funcPlaced, // Function received a pin
	output logic [`PXB_NPINS-1:0] padOut, // Pad output value
	output logic [`PXB_NPINS-1:0] padOe, // Pad output enable, high while driving
	output logic [`PXB_NPINS-1:0] pinOwned, // Pin claimed by the crossbar
	output logic [`PXB_NPINS-1:0] eventIn // Pad levels for event capture logic
);
	// ------------------------------------------------------------
	// Select and reserve registers
	// ------------------------------------------------------------
	logic [7:0] selA_r, selB_r, selC_r, mask0_r, mask1_r;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			selA_r <= `PXB_SEL_RESET;
			selB_r <= `PXB_SEL_RESET;
			selC_r <= `PXB_SEL_RESET;
			mask0_r <= `PXB_MASK_RESET;
			mask1_r <= `PXB_MASK_RESET;
		end else if (clkEn) begin
			if (selWrA) selA_r <= wrData;
			if (selWrB) selB_r <= {1'b0, wrData[6:0]};
			if (selWrC) selC_r <= wrData;
			if (maskWr0) mask0_r <= wrData;
			if (maskWr1) mask1_r <= wrData;
		end
	end

	assign routeSelectA = selA_r;
	assign routeSelectB = selB_r;
	assign routeSelectC = selC_r;
	assign port0ReserveMask = mask0_r;
	assign port1ReserveMask = mask1_r;

	// ------------------------------------------------------------
	// Function enables in priority order
	// ------------------------------------------------------------
	// Order: SCK MISO MOSI NSS, SDA SCL, CP0 COMPARATOR0_ASYNC_OUT, CP1 COMPARATOR1_ASYNC_OUT, SYSCLK, CAPCOMP_OUT0-5, EXT_COUNTER_INPUT, T0, T1.
	wire logic [`PXB_NPINS-1:0] skipMask;
	wire logic [2:0] capCount;
	wire logic fourWire;
	wire logic globalOn;
	wire logic uartOn;
	wire logic spi2On;
	wire logic spi1On;
	wire logic smbOn;
	wire logic [5:0] capOn;
	wire logic [`PXB_NFUNC-1:0] want;

	assign skipMask = {mask1_r[6:0], mask0_r};
	assign capCount = selB_r[`PXB_SELB_CAP_LSB+2:`PXB_SELB_CAP_LSB];
	assign fourWire = slaveSelectMode[`PXB_NSSMD_4WIRE_BIT];
	assign globalOn = selC_r[`PXB_SELC_GLOBAL];
	assign uartOn = selA_r[`PXB_SELA_UART];
	assign spi2On = selB_r[`PXB_SELB_SPI2];
	assign spi1On = selA_r[`PXB_SELA_SECOND_SERIAL_PERIPH];
	assign smbOn = selA_r[`PXB_SELA_SMB];

	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : gCap
			// Reserved code routes nothing.
			assign capOn[g] = (capCount != `PXB_CAP_RESERVED) && (capCount > 3'(g));
		end
	endgenerate

	assign want = {
		selB_r[`PXB_SELB_T1], selB_r[`PXB_SELB_T0], selB_r[`PXB_SELB_ECI],
		capOn[5], capOn[4], capOn[3], capOn[2], capOn[1], capOn[0],
		selA_r[`PXB_SELA_SYSCK],
		selA_r[`PXB_SELA_COMPARATOR1_ASYNC_OUT], selA_r[`PXB_SELA_CP1],
		selA_r[`PXB_SELA_COMPARATOR0_ASYNC_OUT], selA_r[`PXB_SELA_CP0],
		smbOn, smbOn,
		spi1On & fourWire, spi1On, spi1On, spi1On
	};

	// ------------------------------------------------------------
	// Fixed claims and priority search
	// ------------------------------------------------------------
	wire logic [`PXB_NPINS-1:0] fixedUart;
	wire logic [`PXB_NPINS-1:0] fixedSpi2;
	wire logic [`PXB_NPINS-1:0] fixedMask;
	wire logic [`PXB_NPINS-1:0] freeChain [0:`PXB_NFUNC];
	wire logic [`PXB_NPINS-1:0] grant [0:`PXB_NFUNC-1];

	assign fixedUart = uartOn ? ((`PXB_NPINS'(1) << `PXB_UART_TX_PIN) |
		(`PXB_NPINS'(1) << `PXB_UART_RX_PIN)) : '0;
	assign fixedSpi2 = spi2On ? (`PXB_NPINS'(4'hf) << `PXB_SPI2_BASE_PIN) : '0;
	assign fixedMask = fixedUart | fixedSpi2;
	// Fixed pins are claimed even if masked; the masks only keep pins from the priority search.
	assign freeChain[0] = ~skipMask & ~fixedMask;

	generate
		for (g = 0; g < `PXB_NFUNC; g++) begin : gSearch
			// Purely combinational chain, so changes take effect at once.
			pxb_pin_search uSearch (
				.want(want[g]),
				.freeIn(freeChain[g]),
				.freeOut(freeChain[g+1]),
				.grant(grant[g]),
				.found(funcPlaced[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Pad drive mux
	// ------------------------------------------------------------
	wire logic [`PXB_NPINS-1:0] smbPins;
	assign smbPins = grant[4] | grant[5];
	// A searched pin is one that was free at the start of the chain and is gone at its end.
	assign pinOwned = fixedMask | (freeChain[0] & ~freeChain[`PXB_NFUNC]);

	generate
		for (g = 0; g < `PXB_NPINS; g++) begin : gPin
			logic fOut, fOe;
			logic value, drvEn;
			pxb_pkg::pxb_own_e kind;
			wire logic isTx, isSpi2;
			wire logic [1:0] spiIdx;
			wire logic openDrain;
			assign isTx = fixedUart[g] && (g == `PXB_UART_TX_PIN);
			assign isSpi2 = fixedSpi2[g];
			// Only pins 8 to 11 use this index; the cast keeps the other pins in range.
			assign spiIdx = 2'(g - `PXB_SPI2_BASE_PIN);
			assign kind = fixedMask[g] ? pxb_pkg::PXB_OWN_FIXED :
				pinOwned[g] ? pxb_pkg::PXB_OWN_SEARCH : pxb_pkg::PXB_OWN_GPIO;
			always_comb begin
				fOut = 1'b1;
				fOe = 1'b0;
				for (int f = 0; f < `PXB_NFUNC; f++) begin
					if (grant[f][g]) begin
						fOut = periphOut[f];
						fOe = periphOe[f];
					end
				end
			end
			always_comb begin
				value = portLatch[g];
				drvEn = 1'b1;
				unique case (kind)
					pxb_pkg::PXB_OWN_GPIO: begin
						value = portLatch[g];
						drvEn = 1'b1;
					end
					pxb_pkg::PXB_OWN_FIXED: begin
						if (isTx) begin
							value = uartTx;
						end else if (isSpi2) begin
							value = spi2Out[spiIdx];
							drvEn = spi2Oe[spiIdx];
						end else begin
							// The receive pin is an input, so it is left to its pull-up.
							value = 1'b1;
							drvEn = 1'b0;
						end
					end
					pxb_pkg::PXB_OWN_SEARCH: begin
						// A routed function that is not driving leaves its pin high and released.
						value = fOe ? fOut : 1'b1;
						drvEn = fOe;
					end
				endcase
			end
			assign openDrain = !pinDriveType[g] || (smbOn && smbPins[g]);
			assign padOut[g] = value;
			// Open-drain drives only a low; push-pull drives both levels.
			assign padOe[g] = globalOn && pinDigital[g] && drvEn && (openDrain ? !value : 1'b1);
			// Analog pins have no digital receiver, so events never see them.
			assign eventIn[g] = pinDigital[g] & padIn[g];
		end
	endgenerate

	// ------------------------------------------------------------
	// Input return paths
	// ------------------------------------------------------------
	assign uartRx = uartOn ? padIn[`PXB_UART_RX_PIN] : 1'b1;
	assign spi2In = spi2On ? padIn[`PXB_SPI2_BASE_PIN +: 4] : 4'hf;

	generate
		for (g = 0; g < `PXB_NFUNC; g++) begin : gRet
			assign periphIn[g] = funcPlaced[g] ? |(grant[g] & padIn) : 1'b1;
		end
	endgenerate
endmodule

// ===== tb/pxb_crossbar_asserts.sv
// Concurrent checks on the crossbar decoder ports.
`timescale 1ns/1ps
module pxb_crossbar_asserts (
	input wire logic clk_sys, // Clock
	input wire logic rst, // Reset
	input wire logic clkEn, // Write enable
	input wire logic selWrA, // Select a strobe
	input wire logic [7:0] wrData, // Write data
	input wire logic [7:0] routeSelectA, // Select a
	input wire logic [7:0] routeSelectB, // Select b
	input wire logic [7:0] routeSelectC, // Select c
	input wire logic [7:0] port0ReserveMask, // Mask 0
	input wire logic [7:0] port1ReserveMask, // Mask 1
	input wire logic [1:0] slaveSelectMode, // Wire mode
	input wire logic [14:0] pinDigital, // Digital mode
	input wire logic [14:0] padIn, // Pad levels
	input wire logic [20:0] funcPlaced, // Placed
	input wire logic [14:0] padOe, // Drive
	input wire logic [14:0] pinOwned, // Owned
	input wire logic [14:0] eventIn // Event levels
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_wrA; clkEn && selWrA; endsequence
	property p_wrA; s_wrA |=> routeSelectA == $past(wrData); endproperty
	a_wrA: assert property (p_wrA) else $error("select a write lost");
	property p_hold; !clkEn |=> $stable(routeSelectA); endproperty
	a_hold: assert property (p_hold) else $error("select a changed while frozen");
	property p_off; !routeSelectC[6] |-> padOe == 15'h0000; endproperty
	a_off: assert property (p_off) else $error("pad driven while disabled");
	property p_skip; (pinOwned & {port1ReserveMask[6:0], port0ReserveMask} & ~15'h0F30) == 15'h0000; endproperty
	a_skip: assert property (p_skip) else $error("reserved pin claimed");
	property p_uart; routeSelectA[0] |-> pinOwned[5:4] == 2'b11; endproperty
	a_uart: assert property (p_uart) else $error("serial pins not fixed");
	property p_spi2; routeSelectB[6] |-> pinOwned[11:8] == 4'hF; endproperty
	a_spi2: assert property (p_spi2) else $error("second port pins not fixed");
	property p_nss; routeSelectA[1] && !slaveSelectMode[1] |-> !funcPlaced[3] && funcPlaced[2:0] == 3'h7; endproperty
	a_nss: assert property (p_nss) else $error("slave select placed in 3-wire");
	property p_cap; routeSelectB[2:0] == 3'h7 |-> funcPlaced[16:11] == 6'h00; endproperty
	a_cap: assert property (p_cap) else $error("reserved capture code routed");
	property p_b7; routeSelectB[7] == 1'b0; endproperty
	a_b7: assert property (p_b7) else $error("unused select bit set");
	property p_evt; eventIn == (padIn & pinDigital); endproperty
	a_evt: assert property (p_evt) else $error("event level wrong");
endmodule

// ===== tb/pxb_pad_model.sv
// Pad model: a driven pad shows its level, a released one is weakly pulled up.
`timescale 1ns/1ps
module pxb_pad_model (
	input wire logic [14:0] padOut, // Level driven
	input wire logic [14:0] padOe, // Driven when one
	output logic [14:0] padIn // Level at each pad
);
	assign padIn = (padOut & padOe) | ~padOe;
endmodule

// ===== tb/priority_crossbar_decoder_tb.sv
// Self-checking bench for the crossbar decoder.
`timescale 1ns/1ps
module priority_crossbar_decoder_tb;
	logic clk_sys, rst, clkEn, uartTx, uartRx;
	logic [4:0] wrs;
	logic [7:0] wrData, rA, rB, rC, m0, m1;
	logic [1:0] slaveSelectMode;
	logic [14:0] pinDriveType, pinDigital, portLatch, padIn, padOut, padOe, pinOwned, eventIn;
	logic [20:0] periphOut, periphOe, periphIn, funcPlaced;
	logic [3:0] spi2Out, spi2Oe, spi2In;
	int num_errors = 0;
	int n_tests = 0;
	int n;
	pxb_crossbar i_dut (.clk_sys, .rst, .clkEn, .selWrA(wrs[0]), .selWrB(wrs[1]), .selWrC(wrs[2]),
		.maskWr0(wrs[3]), .maskWr1(wrs[4]), .wrData, .routeSelectA(rA), .routeSelectB(rB), .routeSelectC(rC),
		.port0ReserveMask(m0), .port1ReserveMask(m1), .slaveSelectMode, .pinDriveType, .pinDigital, .portLatch,
		.padIn, .periphOut, .periphOe, .uartTx, .spi2Out, .spi2Oe, .uartRx, .spi2In, .periphIn, .funcPlaced,
		.padOut, .padOe, .pinOwned, .eventIn);
	pxb_pad_model i_pads (.padOut, .padOe, .padIn);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input int r, input logic [7:0] d);
		@(negedge clk_sys);
		wrs[r] = 1'b1;
		wrData = d;
		@(negedge clk_sys);
		wrs = 5'h00;
	endtask
	task automatic results();
		$display("errors=%0d checks=%0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#20000;
		num_errors++;
		results();
	end
	initial begin
		rst = 1'b1; clkEn = 1'b1; wrs = 5'h00; wrData = 8'h00; slaveSelectMode = 2'b10; uartTx = 1'b1;
		pinDriveType = 15'h7FFF; pinDigital = 15'h7FFF; portLatch = 15'h2A5C; periphOut = '0; periphOe = '0;
		spi2Out = 4'h0; spi2Oe = 4'h0;
		repeat (20) @(negedge clk_sys);
		rst = 1'b0;
		chk({rA, rB, rC, m0}, 32'h0000_0000);
		chk({m1, padOe}, 32'h0000_0000);
		chk(eventIn, 15'h7FFF);
		wr(2, 8'h40);
		chk({padOut, padOe}, {portLatch, 15'h7FFF});
		wr(0, 8'h01);
		chk(pinOwned, 15'h0030);
		uartTx = 1'b0;
		#1 chk({padOut[5:4], padOe[5:4], uartRx, eventIn[4]}, 6'b100110);
		uartTx = 1'b1;
		wr(1, 8'h80);
		chk(rB, 8'h00);
		wr(0, 8'h07);
		chk(pinOwned, 15'h00FF);
		slaveSelectMode = 2'b00;
		#1 chk({funcPlaced[5:0], pinOwned}, {6'h37, 15'h007F});
		slaveSelectMode = 2'b10;
		wr(3, 8'h0C);
		chk(pinOwned, 15'h03F3);
		periphOe[4] = 1'b1; periphOut[4] = 1'b1;
		#1 chk(padOe[8], 1'b0);
		periphOut[4] = 1'b0;
		#1 chk({padOe[8], padOut[8]}, 2'b10);
		wr(1, 8'h40);
		chk(pinOwned, 15'h3FF3);
		spi2Oe = 4'h5;
		#1 chk({spi2In, padOe[11:8]}, 8'hA5);
		spi2Oe = 4'h0;
		wr(0, 8'h00); wr(3, 8'h00);
		for (n = 0; n < 8; n++) begin
			wr(1, n[7:0]);
			chk({funcPlaced[16:11], pinOwned}, (n == 7) ? 0 : {6'((1 << n) - 1), 15'((1 << n) - 1)});
		end
		wr(0, 8'hFE); wr(1, 8'h39);
		slaveSelectMode = 2'b00; periphOe = '1; periphOut = 21'h15_5555;
		pinDriveType = 15'h7FFE;
		#1 chk({funcPlaced, pinOwned}, {21'h0E_0FF7, 15'h3FFF});
		chk({padOut[10:0], padOe[10:0]}, {11'h2AD, 11'h7F6});
		chk(periphIn, 21'h15_F55D);
		wr(2, 8'h00);
		chk(padOe, 15'h0000);
		pinDigital = 15'h00FF;
		#1 chk(eventIn, 15'h00FF);
		clkEn = 1'b0;
		wr(0, 8'h01);
		chk(rA, 8'hFE);
		clkEn = 1'b1;
		rst = 1'b1;
		@(negedge clk_sys);
		rst = 1'b0;
		chk({rA, rB, rC, m0}, 32'h0000_0000);
		results();
	end
endmodule
bind pxb_crossbar pxb_crossbar_asserts i_chk (.clk_sys, .rst, .clkEn, .selWrA, .wrData, .routeSelectA, .routeSelectB,
	.routeSelectC, .port0ReserveMask, .port1ReserveMask, .slaveSelectMode, .pinDigital, .padIn, .funcPlaced, .padOe,
	.pinOwned, .eventIn);
